//--- verilog/slf_pkg.sv
package slf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE    = 8'h84;
  localparam logic [7:0] IDX_PWR     = 8'h87;
  localparam logic [7:0] IDX_BAUD    = 8'h94;
  localparam logic [7:0] IDX_MATCH0  = 8'h95;
  localparam logic [7:0] IDX_GAP     = 8'ha4;
  localparam logic [7:0] IDX_MATCH1  = 8'ha5;
  localparam logic [7:0] IDX_MATCH2  = 8'hb5;
  localparam logic [7:0] IDX_BACKOFF = 8'hc4;
  localparam logic [7:0] IDX_MATCH3  = 8'hc5;
  localparam logic [7:0] IDX_SLOTCFG = 8'hc6;
  localparam logic [7:0] IDX_COLL    = 8'hd4;
  localparam logic [7:0] IDX_MASK0   = 8'hd5;
  localparam logic [7:0] IDX_RANDOM  = 8'he4;
  localparam logic [7:0] IDX_MASK1   = 8'he5;
  localparam logic [7:0] IDX_RXCTL   = 8'he8;
  localparam logic [7:0] IDX_SLOTLEN = 8'h0b;
  // Mode register fields
  localparam int MODE_PROTO = 0;
  localparam int MODE_PL_LO = 1;
  localparam int MODE_CRC   = 3;
  localparam int MODE_AW    = 4;
  localparam int MODE_M_LO  = 5;
  localparam int MODE_EXT_TX_CLOCK_SEL = 7;
  // Power/link control fields
  localparam int PWR_IDLEFL = 2;
  localparam int PWR_EXT_RX_CLOCK_SEL  = 3;
  localparam int PWR_AUXRX  = 4;
  localparam logic [7:0] PWR_MASK = 8'h1c;
  // Slot config fields
  localparam int SLOT_DCR = 6;
  localparam int SLOT_DCJ = 7;
  // Receive control field
  localparam int RXCTL_EN = 1;
  // Reset values
  localparam logic [7:0] RST_CFG    = 8'h00;
  localparam logic [7:0] RST_RANDOM = 8'h00;
  // Timing
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [6:0] GAP_HALF_ZERO = 7'h7f;
  localparam logic [8:0] SLOT_ZERO_LEN = 9'h100;
  localparam logic [7:0] ALL_ONES      = 8'hff;
  // Operating modes and backoff states
  typedef enum logic [1:0] {
    SLF_M_NORMAL = 2'h0,
    SLF_M_RAWTX  = 2'h1,
    SLF_M_RAWRX  = 2'h2,
    SLF_M_ALT    = 2'h3
  } slf_mode_t;
  typedef enum logic [1:0] {
    SLF_BO_IDLE = 2'h0,
    SLF_BO_GAP  = 2'h1,
    SLF_BO_RUN  = 2'h3
  } slf_bo_t;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verilog/slf_framer.sv
// Summary of operation
// - 8-bit mode: match any of four registers
// - 16-bit mode: match pair 1:0 or 3:2
// - Mask ones make match 0/1 bits don't-care
// - All-ones address always accepted
// - Bit rate is clock over 8*(divisor+1)
// - Divisor writes reload; reads give live count
// - Backoff: 8-bit slot down-counter, read-only
// - Protocol bit: flag/NRZI or Manchester/carrier-sense
// - Preamble 0/8/32/64 bits, BOF handling per protocol
// - CRC bit selects 32-bit or 16-bit polynomial
// - Mode bits: normal, raw tx, raw rx, alternate
// - Raw receive stores all bytes including CRC
// - Raw transmit loops back, no framing added
// - External transmit clock replaces rate generator
// - External receive clock samples receiver
// - Gap: half value counted down twice
// - Slot address 63 first, zero waits all
// - Deterministic slots, no gap retrigger on carrier
// - Jam type bit: DC when set, AC clear
// - Idle flags between frames in flag mode only
// - Aux receive keeps receiver on at end flag in flag mode only; rx_enabled still clears
// - Random generator resets zero, freezes at ones
// - Collision shifts count left, fills one, overflow halts
// - Slot length in bit times, zero gives 256
module slf_framer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Line clocks and data
  input  wire logic        tx_clock_pin,
  input  wire logic        rx_clock_pin,
  input  wire logic        rx_line_pin,
  input  wire logic        tx_serial,
  output logic             rx_serial,
  output logic             tx_bit_tick,
  output logic             rx_bit_tick,
  // Address recognition
  input  wire logic [15:0] rx_addr,
  input  wire logic        rx_addr_valid,
  output logic             addr_accept,
  // Frame events
  input  wire logic        rx_end_flag,
  input  wire logic        gap_start,
  input  wire logic        carrier_seen,
  input  wire logic        collision,
  output logic             gap_busy,
  output logic             tx_permit,
  output logic             tx_halt,
  output logic             slot_tick,
  // Framing configuration
  output logic             flag_nrzi_mode,
  output logic [6:0]       preamble_bits,
  output logic             bof_in_preamble,
  output logic             crc32_sel,
  output logic             raw_tx,
  output logic             raw_rx,
  output logic             store_crc_bytes,
  output logic             zero_insert_en,
  output logic             dc_jam,
  output logic             idle_flags,
  output logic             rx_enabled,
  output logic             rx_stop_on_eof
);
  // Config registers
  logic [7:0] mode_ff, pwr_ff, reload_ff, gap_cfg_ff;
  logic [7:0] m0_ff, m1_ff, m2_ff, m3_ff, k0_ff, k1_ff;
  logic [7:0] slotcfg_ff, slotlen_ff;
  logic [7:0] nxt_mode, nxt_pwr, nxt_reload, nxt_gap_cfg;
  logic [7:0] nxt_m0, nxt_m1, nxt_m2, nxt_m3, nxt_k0, nxt_k1;
  logic [7:0] nxt_slotcfg, nxt_slotlen;
  logic       rxen_ff, nxt_rxen;
  // Bus
  logic       bvalid_ff, rvalid_ff, nxt_bvalid, nxt_rvalid;
  logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       wr_go, rd_go, wr_hit, rd_hit;
  logic [7:0] wi, ri, wd;
  // Timers
  logic [2:0] pre_ff, nxt_pre;
  logic [7:0] baud_ff, nxt_baud;
  logic       tclk_ff, rclk_ff, nxt_tclk, nxt_rclk;
  logic       gen_tick, ext_tx_edge, ext_rx_edge;
  logic [6:0] gap_ff, nxt_gap;
  logic       gap_phase_ff, gap_run_ff, nxt_gap_phase, nxt_gap_run;
  logic       gap_done;
  logic [8:0] slot_ff, nxt_slot;
  logic [7:0] bo_ff, nxt_bo, coll_ff, nxt_coll;
  logic [7:0] rnd_ff, nxt_rnd;
  logic       halt_ff, nxt_halt;
  logic [7:0] bo_load;
  logic       acc_ff, nxt_acc;
  slf_pkg::slf_bo_t  bo_st_ff, nxt_bo_st;
  slf_pkg::slf_mode_t mode_sel;

  assign mode_sel = slf_pkg::slf_mode_t'(mode_ff[slf_pkg::MODE_M_LO +: 2]);
  assign wi = s_axi_awaddr[9:2];
  assign ri = s_axi_araddr[9:2];
  assign wd = s_axi_wdata[7:0];

  // One write and one read at a time; address and data taken together
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_go = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = {24'h000000, rdata_ff};

  always_comb begin
    wr_hit = 1'b1;
    unique case (wi)
      slf_pkg::IDX_MODE, slf_pkg::IDX_PWR, slf_pkg::IDX_BAUD,
      slf_pkg::IDX_MATCH0, slf_pkg::IDX_MATCH1, slf_pkg::IDX_MATCH2,
      slf_pkg::IDX_MATCH3, slf_pkg::IDX_MASK0, slf_pkg::IDX_MASK1,
      slf_pkg::IDX_GAP, slf_pkg::IDX_BACKOFF, slf_pkg::IDX_SLOTCFG,
      slf_pkg::IDX_COLL, slf_pkg::IDX_RANDOM, slf_pkg::IDX_RXCTL,
      slf_pkg::IDX_SLOTLEN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    if (s_axi_awaddr[31:10] != 22'h000000) begin
      wr_hit = 1'b0;
    end
  end

  // Register writes (byte lane 0 only)
  always_comb begin
    logic we;
    we = wr_go && wr_hit && s_axi_wstrb[0];
    nxt_mode    = mode_ff;
    nxt_pwr     = pwr_ff;
    nxt_reload  = reload_ff;
    nxt_gap_cfg = gap_cfg_ff;
    nxt_m0      = m0_ff;
    nxt_m1      = m1_ff;
    nxt_m2      = m2_ff;
    nxt_m3      = m3_ff;
    nxt_k0      = k0_ff;
    nxt_k1      = k1_ff;
    nxt_slotcfg = slotcfg_ff;
    nxt_slotlen = slotlen_ff;
    nxt_rxen    = rxen_ff;
    if (we) begin
      unique case (wi)
        slf_pkg::IDX_MODE:    nxt_mode = wd;
        slf_pkg::IDX_PWR:     nxt_pwr = wd & slf_pkg::PWR_MASK;
        slf_pkg::IDX_BAUD:    nxt_reload = wd;
        slf_pkg::IDX_MATCH0:  nxt_m0 = wd;
        slf_pkg::IDX_MATCH1:  nxt_m1 = wd;
        slf_pkg::IDX_MATCH2:  nxt_m2 = wd;
        slf_pkg::IDX_MATCH3:  nxt_m3 = wd;
        slf_pkg::IDX_MASK0:   nxt_k0 = wd;
        slf_pkg::IDX_MASK1:   nxt_k1 = wd;
        slf_pkg::IDX_GAP:     nxt_gap_cfg = wd;
        slf_pkg::IDX_SLOTCFG: nxt_slotcfg = wd;
        slf_pkg::IDX_SLOTLEN: nxt_slotlen = wd;
        slf_pkg::IDX_RXCTL:   nxt_rxen = wd[slf_pkg::RXCTL_EN];
        default: ;
      endcase
    end
    // End flag clears the enable even if software sets it this cycle
    if (rx_end_flag) begin
      nxt_rxen = 1'b0;
    end
  end

  // Read data and responses
  always_comb begin
    rd_hit    = s_axi_araddr[31:10] == 22'h000000;
    nxt_rdata = rdata_ff;
    unique case (ri)
      slf_pkg::IDX_MODE:    nxt_rdata = mode_ff;
      slf_pkg::IDX_PWR:     nxt_rdata = pwr_ff;
      slf_pkg::IDX_BAUD:    nxt_rdata = baud_ff;
      slf_pkg::IDX_MATCH0:  nxt_rdata = m0_ff;
      slf_pkg::IDX_MATCH1:  nxt_rdata = m1_ff;
      slf_pkg::IDX_MATCH2:  nxt_rdata = m2_ff;
      slf_pkg::IDX_MATCH3:  nxt_rdata = m3_ff;
      slf_pkg::IDX_MASK0:   nxt_rdata = k0_ff;
      slf_pkg::IDX_MASK1:   nxt_rdata = k1_ff;
      slf_pkg::IDX_GAP:     nxt_rdata = {gap_ff, gap_phase_ff};
      slf_pkg::IDX_BACKOFF: nxt_rdata = bo_ff;
      slf_pkg::IDX_SLOTCFG: nxt_rdata = slotcfg_ff;
      slf_pkg::IDX_COLL:    nxt_rdata = coll_ff;
      slf_pkg::IDX_RANDOM:  nxt_rdata = rnd_ff;
      slf_pkg::IDX_RXCTL:   nxt_rdata = {6'h00, rxen_ff, 1'b0};
      slf_pkg::IDX_SLOTLEN: nxt_rdata = slot_ff[7:0];
      default:              rd_hit = 1'b0;
    endcase
    if (!rd_hit) begin
      nxt_rdata = 8'h00;
    end
    if (!rd_go) begin
      nxt_rdata = rdata_ff;
    end
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_hit ? slf_pkg::RESP_OKAY : slf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = rd_hit ? slf_pkg::RESP_OKAY : slf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff    <= slf_pkg::RST_CFG;
      pwr_ff     <= slf_pkg::RST_CFG;
      reload_ff  <= slf_pkg::RST_CFG;
      gap_cfg_ff <= slf_pkg::RST_CFG;
      m0_ff      <= slf_pkg::RST_CFG;
      m1_ff      <= slf_pkg::RST_CFG;
      m2_ff      <= slf_pkg::RST_CFG;
      m3_ff      <= slf_pkg::RST_CFG;
      k0_ff      <= slf_pkg::RST_CFG;
      k1_ff      <= slf_pkg::RST_CFG;
      slotcfg_ff <= slf_pkg::RST_CFG;
      slotlen_ff <= slf_pkg::RST_CFG;
      rxen_ff    <= 1'b0;
      bvalid_ff  <= 1'b0;
      rvalid_ff  <= 1'b0;
      bresp_ff   <= slf_pkg::RESP_OKAY;
      rresp_ff   <= slf_pkg::RESP_OKAY;
      rdata_ff   <= 8'h00;
    end else begin
      mode_ff    <= nxt_mode;
      pwr_ff     <= nxt_pwr;
      reload_ff  <= nxt_reload;
      gap_cfg_ff <= nxt_gap_cfg;
      m0_ff      <= nxt_m0;
      m1_ff      <= nxt_m1;
      m2_ff      <= nxt_m2;
      m3_ff      <= nxt_m3;
      k0_ff      <= nxt_k0;
      k1_ff      <= nxt_k1;
      slotcfg_ff <= nxt_slotcfg;
      slotlen_ff <= nxt_slotlen;
      rxen_ff    <= nxt_rxen;
      bvalid_ff  <= nxt_bvalid;
      rvalid_ff  <= nxt_rvalid;
      bresp_ff   <= nxt_bresp;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

  // Bit clocks: prescale by 8, then divisor down-counter
  always_comb begin
    nxt_pre  = pre_ff + 3'h1;
    nxt_baud = baud_ff;
    gen_tick = 1'b0;
    if (pre_ff == slf_pkg::PRESCALE_LAST) begin
      if (baud_ff == 8'h00) begin
        nxt_baud = reload_ff;
        gen_tick = 1'b1;
      end else begin
        nxt_baud = baud_ff - 8'h01;
      end
    end
    nxt_tclk    = tx_clock_pin;
    nxt_rclk    = rx_clock_pin;
    ext_tx_edge = tx_clock_pin && !tclk_ff;
    ext_rx_edge = rx_clock_pin && !rclk_ff;
  end

  assign tx_bit_tick = mode_ff[slf_pkg::MODE_EXT_TX_CLOCK_SEL] ? ext_tx_edge : gen_tick;
  assign rx_bit_tick = pwr_ff[slf_pkg::PWR_EXT_RX_CLOCK_SEL] ? ext_rx_edge : gen_tick;

  // Gap timer: half value counted down twice
  always_comb begin
    nxt_gap       = gap_ff;
    nxt_gap_phase = gap_phase_ff;
    nxt_gap_run   = gap_run_ff;
    gap_done      = 1'b0;
    if (gap_start || (carrier_seen && !slotcfg_ff[slf_pkg::SLOT_DCR])) begin
      nxt_gap       = gap_cfg_ff[7:1] - 7'h01;
      nxt_gap_phase = 1'b1;
      nxt_gap_run   = 1'b1;
    end else if (gap_run_ff && tx_bit_tick) begin
      if (gap_ff != 7'h00) begin
        nxt_gap = gap_ff - 7'h01;
      end else if (gap_phase_ff) begin
        nxt_gap       = gap_cfg_ff[7:1] - 7'h01;
        nxt_gap_phase = 1'b0;
      end else begin
        nxt_gap_run = 1'b0;
        gap_done    = 1'b1;
      end
    end
  end

  // Zero written gives 0x7f per pass: 128 twice is 256 bit times
  assign gap_busy = gap_run_ff;

  // Slot timer runs from the transmit bit clock
  always_comb begin
    nxt_slot  = slot_ff;
    slot_tick = 1'b0;
    if (tx_bit_tick) begin
      if (slot_ff <= 9'h001) begin
        nxt_slot  = (slotlen_ff == 8'h00) ? slf_pkg::SLOT_ZERO_LEN : {1'b0, slotlen_ff};
        slot_tick = 1'b1;
      end else begin
        nxt_slot = slot_ff - 9'h001;
      end
    end
  end

  // Random generator: XNOR feedback, so all ones is its lock state
  always_comb begin
    nxt_rnd = {rnd_ff[6:0], ~(rnd_ff[7] ^ rnd_ff[5] ^ rnd_ff[4] ^ rnd_ff[3])};
    if (wr_go && s_axi_wstrb[0] && wi == slf_pkg::IDX_RANDOM) begin
      nxt_rnd = wd;
    end
  end

  // Deterministic wait shortens with a higher slot address
  always_comb begin
    if (slotcfg_ff[slf_pkg::SLOT_DCR]) begin
      bo_load = coll_ff - {2'b00, slotcfg_ff[5:0]};
      if ({2'b00, slotcfg_ff[5:0]} > coll_ff) begin
        bo_load = 8'h00;
      end
    end else begin
      bo_load = rnd_ff & coll_ff;
    end
  end

  // Collision count, halt and backoff sequencing
  always_comb begin
    nxt_coll  = coll_ff;
    nxt_halt  = halt_ff;
    nxt_bo    = bo_ff;
    nxt_bo_st = bo_st_ff;
    if (wr_go && s_axi_wstrb[0] && wi == slf_pkg::IDX_COLL) begin
      nxt_coll = wd;
      nxt_halt = 1'b0;
    end
    if (collision) begin
      nxt_coll = {coll_ff[6:0], 1'b1};
      if (coll_ff[7]) begin
        nxt_halt = 1'b1;
      end
    end
    unique case (bo_st_ff)
      slf_pkg::SLF_BO_IDLE: begin
        if (collision) begin
          nxt_bo    = bo_load;
          // Alternate mode holds backoff until the gap is over
          nxt_bo_st = (mode_sel == slf_pkg::SLF_M_ALT) ? slf_pkg::SLF_BO_GAP : slf_pkg::SLF_BO_RUN;
        end
      end
      slf_pkg::SLF_BO_GAP: begin
        if (!gap_run_ff || gap_done) begin
          nxt_bo_st = slf_pkg::SLF_BO_RUN;
        end
      end
      slf_pkg::SLF_BO_RUN: begin
        if (bo_ff == 8'h00) begin
          nxt_bo_st = slf_pkg::SLF_BO_IDLE;
        end else if (slot_tick) begin
          nxt_bo = bo_ff - 8'h01;
        end
      end
      default: nxt_bo_st = slf_pkg::SLF_BO_IDLE;
    endcase
  end

  // Normal mode: the longer of gap and backoff
  assign tx_permit = (bo_st_ff == slf_pkg::SLF_BO_IDLE) && !gap_run_ff && !halt_ff;
  assign tx_halt   = halt_ff;

  // Address recognition
  always_comb begin
    logic h0, h1, h2, h3;
    logic [15:0] mk;
    mk  = {k1_ff, k0_ff};
    h0  = ((rx_addr[7:0] ^ m0_ff) & ~k0_ff) == 8'h00;
    h1  = ((rx_addr[7:0] ^ m1_ff) & ~k1_ff) == 8'h00;
    h2  = rx_addr[7:0] == m2_ff;
    h3  = rx_addr[7:0] == m3_ff;
    nxt_acc = acc_ff;
    if (rx_addr_valid) begin
      if (mode_ff[slf_pkg::MODE_AW]) begin
        nxt_acc = (((rx_addr ^ {m1_ff, m0_ff}) & ~mk) == 16'h0000)
               || (rx_addr == {m3_ff, m2_ff})
               || (rx_addr == 16'hffff);
      end else begin
        nxt_acc = h0 || h1 || h2 || h3 || (rx_addr[7:0] == slf_pkg::ALL_ONES);
      end
    end
  end

  assign addr_accept = acc_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_ff       <= 3'h0;
      baud_ff      <= 8'h00;
      tclk_ff      <= 1'b0;
      rclk_ff      <= 1'b0;
      gap_ff       <= 7'h00;
      gap_phase_ff <= 1'b0;
      gap_run_ff   <= 1'b0;
      slot_ff      <= 9'h000;
      rnd_ff       <= slf_pkg::RST_RANDOM;
      coll_ff      <= 8'h00;
      halt_ff      <= 1'b0;
      bo_ff        <= 8'h00;
      bo_st_ff     <= slf_pkg::SLF_BO_IDLE;
      acc_ff       <= 1'b0;
    end else begin
      pre_ff       <= nxt_pre;
      baud_ff      <= nxt_baud;
      tclk_ff      <= nxt_tclk;
      rclk_ff      <= nxt_rclk;
      gap_ff       <= nxt_gap;
      gap_phase_ff <= nxt_gap_phase;
      gap_run_ff   <= nxt_gap_run;
      slot_ff      <= nxt_slot;
      rnd_ff       <= nxt_rnd;
      coll_ff      <= nxt_coll;
      halt_ff      <= nxt_halt;
      bo_ff        <= nxt_bo;
      bo_st_ff     <= nxt_bo_st;
      acc_ff       <= nxt_acc;
    end
  end

  // Framing configuration for the shifters
  assign flag_nrzi_mode  = mode_ff[slf_pkg::MODE_PROTO];
  assign crc32_sel       = mode_ff[slf_pkg::MODE_CRC];
  assign raw_tx          = mode_sel == slf_pkg::SLF_M_RAWTX;
  assign raw_rx          = mode_sel == slf_pkg::SLF_M_RAWRX;
  assign store_crc_bytes = raw_rx;
  // Raw transmit sends no preamble, flags, insertion or CRC
  assign zero_insert_en  = !raw_tx && flag_nrzi_mode;
  assign rx_serial       = raw_tx ? tx_serial : rx_line_pin;
  assign bof_in_preamble = !flag_nrzi_mode;
  assign dc_jam          = slotcfg_ff[slf_pkg::SLOT_DCJ];
  assign idle_flags      = pwr_ff[slf_pkg::PWR_IDLEFL] && flag_nrzi_mode;
  assign rx_enabled      = rxen_ff;
  assign rx_stop_on_eof  = !(pwr_ff[slf_pkg::PWR_AUXRX] && flag_nrzi_mode);

  always_comb begin
    unique case (mode_ff[slf_pkg::MODE_PL_LO +: 2])
      2'h0: preamble_bits = 7'h00;
      2'h1: preamble_bits = 7'h08;
      2'h2: preamble_bits = 7'h20;
      2'h3: preamble_bits = 7'h40;
    endcase
    if (raw_tx) begin
      preamble_bits = 7'h00;
    end
  end
endmodule

//--- test/slf_chk.sv
module slf_chk (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Write channel
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  // Line
  input wire logic       tx_serial,
  input wire logic       rx_line_pin,
  input wire logic       rx_serial,
  input wire logic       tx_bit_tick,
  // Address and events
  input wire logic [15:0] rx_addr,
  input wire logic       rx_addr_valid,
  input wire logic       addr_accept,
  input wire logic       rx_end_flag,
  input wire logic       rx_enabled,
  input wire logic       tx_halt,
  input wire logic       tx_permit,
  // Framing
  input wire logic       flag_nrzi_mode,
  input wire logic [6:0] preamble_bits,
  input wire logic       bof_in_preamble,
  input wire logic       raw_tx,
  input wire logic       raw_rx,
  input wire logic       store_crc_bytes,
  input wire logic       zero_insert_en,
  input wire logic       idle_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Fastest bit clock is eight aclk cycles
  sequence quiet_s;
    !tx_bit_tick [*7];
  endsequence
  wr_answer_a: assert property (take_s |=> s_axi_bvalid)
    else $error("write not answered");
  tick_gap_a: assert property (tx_bit_tick |=> quiet_s)
    else $error("bit ticks too close");
  loop_back_a: assert property (raw_tx |-> rx_serial == tx_serial)
    else $error("loopback missing");
  line_pass_a: assert property (!raw_tx |-> rx_serial == rx_line_pin)
    else $error("line not passed");
  raw_framing_a: assert property (raw_tx |-> preamble_bits == 7'h00 && !zero_insert_en)
    else $error("framing in raw transmit");
  raw_crc_a: assert property (raw_rx |-> store_crc_bytes)
    else $error("crc bytes dropped");
  idle_flag_a: assert property (idle_flags |-> flag_nrzi_mode)
    else $error("idle flags in manchester");
  bof_mark_a: assert property (bof_in_preamble == !flag_nrzi_mode)
    else $error("bof placement wrong");
  pre_len_a: assert property (preamble_bits inside {7'h00, 7'h08, 7'h20, 7'h40})
    else $error("bad preamble length");
  ones_accept_a: assert property (rx_addr_valid && rx_addr == 16'hffff |=> addr_accept)
    else $error("all ones refused");
  eof_clear_a: assert property (rx_end_flag |=> !rx_enabled)
    else $error("receiver enable kept");
  halt_block_a: assert property (tx_halt |-> !tx_permit)
    else $error("permit while halted");
endmodule

bind slf_framer slf_chk slf_chk_i (.*);

//--- test/slf_peer.sv
module slf_peer (
  // Clock
  input wire logic aclk,
  // Frame windows
  input wire logic run_tx,
  input wire logic run_rx,
  // Line side
  output logic     tx_clock_pin,
  output logic     rx_clock_pin,
  output logic     rx_line_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_ff = 4'h0;
  logic       lvl_ff = 1'b0;
  always_ff @(posedge aclk) begin
    div_ff <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
    lvl_ff <= ~lvl_ff;
  end
  // Clocks stand still low outside frames
  assign tx_clock_pin = run_tx & div_ff[3];
  assign rx_clock_pin = run_rx & div_ff[3];
  // Undriven line toggles so a stale level never passes
  assign rx_line_pin  = lvl_ff;
endmodule

//--- test/slf_framer_tb.sv
module slf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, run_tx = 1'b0, run_rx = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, cyc = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] rx_addr = '0;
  logic [4:0]  ev = '0;
  logic [6:0]  preamble_bits;
  logic        tx_clock_pin, rx_clock_pin, rx_line_pin, tx_serial, rx_serial, tx_bit_tick, rx_bit_tick;
  logic        rx_addr_valid, addr_accept, rx_end_flag, gap_start, carrier_seen, collision, gap_busy;
  logic        tx_permit, tx_halt, slot_tick, flag_nrzi_mode, bof_in_preamble, crc32_sel, raw_tx, raw_rx;
  logic        store_crc_bytes, zero_insert_en, dc_jam, idle_flags, rx_enabled, rx_stop_on_eof;
  logic [6:0]  pl_tab [4] = '{7'h00, 7'h08, 7'h20, 7'h40};
  int          n_mismatch = 0, num_checks = 0, n;
  assign {rx_addr_valid, collision, carrier_seen, gap_start, rx_end_flag} = ev;
  assign tx_serial = cyc[1];
  slf_framer slf_framer_i (.*);
  slf_peer slf_peer_i (.aclk, .run_tx, .run_rx, .tx_clock_pin, .rx_clock_pin, .rx_line_pin);
  always #2.5 aclk = ~aclk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 32'h0000_9c40) begin
      n_mismatch++;
      summarize();
    end
  end
  task wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er = slf_pkg::RESP_OKAY);
    logic [1:0] r;
    s_axi_awaddr <= {22'h0, ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", er, r);
  endtask
  task rd(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er = slf_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    s_axi_araddr <= {22'h0, ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, e}, d);
    chk("rresp", er, r);
  endtask
  task pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge aclk);
    ev <= '0;
    @(negedge aclk);
  endtask
  task adr(input logic [15:0] a, input logic e);
    rx_addr <= a;
    pulse(4);
    chk("accept", e, addr_accept);
    @(posedge aclk);
  endtask
  task per(input logic r, output int k);
    repeat (2) do @(negedge aclk); while (!(r ? rx_bit_tick : tx_bit_tick));
    k = 0;
    do begin @(negedge aclk); k++; end while (!(r ? rx_bit_tick : tx_bit_tick));
    @(posedge aclk);
  endtask
  // Gap of four bit times with carrier arriving halfway through
  task gapm(output int k);
    int t;
    t = cyc;
    pulse(1);
    repeat (16) @(posedge aclk);
    pulse(2);
    do @(negedge aclk); while (gap_busy);
    k = cyc - t;
    @(posedge aclk);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(slf_pkg::IDX_MODE, 8'h00);
    wr(slf_pkg::IDX_BACKOFF, 8'h55);
    rd(slf_pkg::IDX_BACKOFF, 8'h00);
    wr(8'h10, 8'h01, slf_pkg::RESP_SLVERR);
    rd(8'h10, 8'h00, slf_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(slf_pkg::IDX_MODE, {1'b0, 2'(i), 1'b0, i[0], 2'(i), i[0]});
      chk("raw_tx", i == 1, raw_tx);
      chk("raw_rx", i == 2, raw_rx);
      chk("crc", i[0], crc32_sel);
      chk("flag", i[0], flag_nrzi_mode);
      chk("pre", (i == 1) ? 7'h00 : pl_tab[i], preamble_bits);
    end
    wr(slf_pkg::IDX_PWR, 8'hff);
    rd(slf_pkg::IDX_PWR, 8'h1c);
    chk("idle", 1, idle_flags);
    chk("stop", 0, rx_stop_on_eof);
    wr(slf_pkg::IDX_MODE, 8'h00);
    chk("idle_m", 0, idle_flags);
    chk("stop_m", 1, rx_stop_on_eof);
    wr(slf_pkg::IDX_RXCTL, 8'h02);
    chk("rx_on", 1, rx_enabled);
    pulse(0);
    chk("rx_off", 0, rx_enabled);
    @(posedge aclk);
    wr(slf_pkg::IDX_PWR, 8'h00);
    wr(slf_pkg::IDX_MATCH0, 8'h11);
    wr(slf_pkg::IDX_MATCH1, 8'h22);
    wr(slf_pkg::IDX_MATCH2, 8'h33);
    wr(slf_pkg::IDX_MATCH3, 8'h44);
    wr(slf_pkg::IDX_MASK0, 8'h0f);
    adr(16'h0044, 1);
    adr(16'h001a, 1);
    adr(16'h0055, 0);
    adr(16'h00ff, 1);
    wr(slf_pkg::IDX_MODE, 8'h10);
    adr(16'h4433, 1);
    adr(16'h221f, 1);
    adr(16'h3344, 0);
    adr(16'hffff, 1);
    wr(slf_pkg::IDX_BAUD, 8'h02);
    per(1'b0, n);
    chk("div2", 24, n);
    wr(slf_pkg::IDX_BAUD, 8'h00);
    per(1'b0, n);
    chk("div0", 8, n);
    wr(slf_pkg::IDX_MODE, 8'h80);
    // Keep a source switch from putting two ticks closer than a bit time
    repeat (8) @(posedge aclk);
    run_tx <= 1'b1;
    per(1'b0, n);
    chk("ext_tx", 10, n);
    wr(slf_pkg::IDX_PWR, 8'h08);
    run_rx <= 1'b1;
    per(1'b1, n);
    chk("ext_rx", 10, n);
    run_tx <= 1'b0;
    run_rx <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(slf_pkg::IDX_MODE, 8'h00);
    wr(slf_pkg::IDX_GAP, 8'h04);
    rd(slf_pkg::IDX_GAP, 8'h00);
    gapm(n);
    chk("retrig", 1, n >= 43);
    wr(slf_pkg::IDX_MODE, 8'h60);
    wr(slf_pkg::IDX_COLL, 8'h3f);
    wr(slf_pkg::IDX_RANDOM, 8'hff);
    wr(slf_pkg::IDX_SLOTCFG, 8'h45);
    chk("ac_jam", 0, dc_jam);
    rd(slf_pkg::IDX_RANDOM, 8'hff);
    gapm(n);
    chk("no_retrig", 1, n <= 33);
    wr(slf_pkg::IDX_SLOTCFG, 8'h80);
    chk("dc_jam", 1, dc_jam);
    wr(slf_pkg::IDX_MODE, 8'h00);
    wr(slf_pkg::IDX_COLL, 8'h7f);
    pulse(3);
    chk("permit", 0, tx_permit);
    @(posedge aclk);
    rd(slf_pkg::IDX_COLL, 8'hff);
    pulse(3);
    chk("halt", 1, tx_halt);
    @(posedge aclk);
    wr(slf_pkg::IDX_COLL, 8'h00);
    chk("unhalt", 0, tx_halt);
    summarize();
  end
endmodule
